// *** dram_ctl_pkg.sv ***
// Package: timing constants, types and states of the strobe-driven DRAM controller
// Functional notes
// - Refresh all 1024 rows every 16 ms
// - Column strobe leads row strobe by 10 ns
// - Column strobe held low after row fall
// - Sample output only after access time; the code waits out column access only, not row access on bit 0
// - Page cycles may mix read and write
// - Row-to-column spacing at least 20 ns
// - Row strobe low 60 ns before cycle end
// - Wait 200 us, then eight init cycles
// - Row-only refresh needs external row address
package dram_ctl_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS        = 40000;
    localparam int COLUMN_LEAD_PS       = 10000;
    localparam int COLUMN_HOLD_PS       = 20000;
    localparam int ROW_TO_COLUMN_PS     = 20000;
    localparam int ROW_LOW_PS           = 60000;
    localparam int ROW_PRECHARGE_PS     = 70000;
    localparam int ACCESS_FROM_ROW_PS   = 100000;
    localparam int ACCESS_FROM_COL_PS   = 25000;
    localparam int POWERUP_US           = 200;
    localparam int REFRESH_PERIOD_MS    = 16;
    localparam int REFRESH_ROWS         = 1024;
    localparam int INIT_CYCLES          = 8;
    localparam int NIBBLE_BITS          = 4;
    localparam int ADDR_BITS            = 11;
    localparam int WORD_ADDR_BITS       = 22;

    function automatic int cyc_up(input int ps);
        cyc_up = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (cyc_up < 1) cyc_up = 1;
    endfunction

    localparam int LEAD_CYC      = cyc_up(COLUMN_LEAD_PS);
    localparam int HOLD_CYC      = cyc_up(COLUMN_HOLD_PS);
    localparam int RCD_CYC       = cyc_up(ROW_TO_COLUMN_PS);
    localparam int RAS_CYC       = cyc_up(ROW_LOW_PS);
    localparam int RP_CYC        = cyc_up(ROW_PRECHARGE_PS);
    localparam int CAC_CYC       = cyc_up(ACCESS_FROM_COL_PS);
    localparam int RAC_CYC       = cyc_up(ACCESS_FROM_ROW_PS);
    localparam int POWERUP_CYC   = POWERUP_US * 1000000 / CLK_PERIOD_PS;
    // Longest time: round the per-row interval down
    localparam int REFRESH_CYC   = REFRESH_PERIOD_MS * 1000 * (1000000 / CLK_PERIOD_PS) / REFRESH_ROWS;

    localparam logic [7:0] T_ZERO = 8'h00;
    localparam logic [7:0] T_ONE  = 8'h01;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic                      write;    // 1 = write, 0 = read
        logic                      nibble;   // 4-bit nibble burst
        logic [WORD_ADDR_BITS-1:0] addr;     // Row in upper half, column in lower
        logic [NIBBLE_BITS-1:0]    wdata;
    } dram_req_t;

    typedef struct packed {
        logic [ADDR_BITS-1:0] multiplexed_address;
        logic                 row_strobe_n;
        logic                 column_strobe_n;
        logic                 store_select_n;
        logic                 input_bit;
    } dram_pins_t;

    typedef enum logic [3:0] {
        ST_POWERUP, ST_INIT, ST_IDLE, ST_CBR_LEAD, ST_CBR_ROW,
        ST_ROW, ST_COL, ST_COL_HIGH, ST_ROW_HOLD, ST_PRECHARGE
    } ctl_state_t;
endpackage

// *** dram_ctl.sv ***
// Module: host-side controller driving a 4M x 1 strobe DRAM
`timescale 1ns/1ps
`default_nettype none
module dram_ctl
    import dram_ctl_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int REFRESH_CYCLES = REFRESH_CYC
) (
    input  wire logic       mclk,       // 25 MHz clock
    input  wire logic       rst,        // Synchronous reset, active high
    input  wire logic       req_valid,  // Access request
    output logic            req_ready,  // Request accepted this cycle
    input  wire dram_req_t  req,        // Request contents
    output logic            rsp_valid,  // Read data valid pulse
    output logic [3:0]      rsp_data,   // Read bits, bit 0 first
    output logic            busy,       // Init, refresh or access in progress
    output dram_pins_t      pins,       // Strobes, address and data to the DRAM
    input  wire logic       output_bit  // Data out pin of the DRAM
);
    initial begin
        if (POWERUP_CYCLES < 1 || REFRESH_CYCLES < 16)
            $error("dram_ctl: bad timing parameters");
    end

    // ------------------------------------------------------------
    // Input synchroniser: change counts once stages two and three agree
    // ------------------------------------------------------------
    logic q_s1, q_s2, q_s3, q_clean;
    always_ff @(posedge mclk) begin
        q_s1 <= output_bit;
        q_s2 <= q_s1;
        q_s3 <= q_s2;
        if (q_s2 == q_s3) q_clean <= q_s3;
    end

    // ------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------
    ctl_state_t state;
    logic [23:0] timer;
    logic [23:0] ref_timer;
    logic [3:0]  init_cnt;
    logic        ref_due, is_ref, ref_pending;
    logic [1:0]  bit_idx;
    dram_req_t   cur;
    logic [9:0]  ext_row;

    wire timer_done = (timer == 24'h000000);
    wire last_bit   = !cur.nibble || (bit_idx == 2'h3);
    // Data sampled late in the column pulse, covering the column access path only (bit 0 also adds just 1), after the sync delay.
    // The filtered bit settles one edge after stages two and three agree, hence four extra cycles.
    wire [23:0] col_len = 24'(((RAC_CYC > CAC_CYC) ? (bit_idx == 2'h0 ? 1 : CAC_CYC) : CAC_CYC) + 4);

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_timer   <= 24'h000000;
            ref_pending <= 1'b0;
        end else if (ref_timer >= 24'(REFRESH_CYCLES - 1)) begin
            ref_timer   <= 24'h000000;
            ref_pending <= 1'b1;
        end else begin
            ref_timer   <= ref_timer + 24'h000001;
            if (state == ST_CBR_LEAD) ref_pending <= 1'b0;
        end
    end
    assign ref_due = ref_pending;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state     <= ST_POWERUP;
            timer     <= 24'(POWERUP_CYCLES);
            init_cnt  <= 4'h0;
            is_ref    <= 1'b0;
            bit_idx   <= 2'h0;
            cur       <= '0;
            ext_row   <= 10'h000;
            rsp_valid <= 1'b0;
            rsp_data  <= 4'h0;
            pins      <= '{multiplexed_address: '0, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                           store_select_n: 1'b1, input_bit: 1'b0};
        end else begin
            rsp_valid <= 1'b0;
            if (!timer_done) timer <= timer - 24'h000001;
            case (state)
                ST_POWERUP: if (timer_done) state <= ST_INIT;
                ST_INIT: begin
                    // First init cycle row-only refresh, remainder column-first refresh
                    if (init_cnt == 4'(INIT_CYCLES)) begin
                        state <= ST_IDLE;
                    end else if (init_cnt == 4'h0) begin
                        init_cnt <= init_cnt + 4'h1;
                        is_ref   <= 1'b0;
                        cur      <= '0;
                        pins.multiplexed_address <= {1'b0, ext_row};
                        ext_row  <= ext_row + 10'h001;
                        pins.row_strobe_n <= 1'b0;
                        timer    <= 24'(RAS_CYC - 1);
                        state    <= ST_ROW_HOLD;
                    end else begin
                        init_cnt <= init_cnt + 4'h1;
                        is_ref   <= 1'b1;
                        pins.store_select_n  <= 1'b1;
                        pins.column_strobe_n <= 1'b0;
                        timer    <= 24'(LEAD_CYC - 1);
                        state    <= ST_CBR_LEAD;
                    end
                end
                ST_IDLE: begin
                    if (ref_due) begin
                        is_ref <= 1'b1;
                        pins.store_select_n  <= 1'b1;
                        pins.column_strobe_n <= 1'b0;
                        timer  <= 24'(LEAD_CYC - 1);
                        state  <= ST_CBR_LEAD;
                    end else if (req_valid) begin
                        is_ref  <= 1'b0;
                        cur     <= req;
                        bit_idx <= 2'h0;
                        pins.multiplexed_address <= req.addr[21:11];
                        pins.row_strobe_n <= 1'b0;
                        // Early write: select set before the column strobe falls
                        pins.store_select_n <= !req.write;
                        timer <= 24'(RCD_CYC - 1);
                        state <= ST_ROW;
                    end
                end
                ST_CBR_LEAD: if (timer_done) begin
                    pins.row_strobe_n <= 1'b0;
                    timer <= 24'(((HOLD_CYC > RAS_CYC) ? HOLD_CYC : RAS_CYC) - 1);
                    state <= ST_ROW_HOLD;
                end
                ST_ROW: if (timer_done) begin
                    pins.multiplexed_address <= cur.addr[10:0];
                    pins.input_bit       <= cur.wdata[0];
                    pins.column_strobe_n <= 1'b0;
                    timer <= col_len - 24'h000001;
                    state <= ST_COL;
                end
                ST_COL: if (timer_done) begin
                    if (!cur.write) begin
                        rsp_data[bit_idx] <= q_clean;
                    end
                    pins.column_strobe_n <= 1'b1;
                    timer <= 24'(LEAD_CYC - 1);
                    state <= last_bit ? ST_ROW_HOLD : ST_COL_HIGH;
                    if (last_bit && !cur.write) rsp_valid <= 1'b1;
                end
                ST_COL_HIGH: if (timer_done) begin
                    // Next nibble bit: device advances on each column strobe fall
                    bit_idx <= bit_idx + 2'h1;
                    pins.input_bit       <= cur.wdata[bit_idx + 2'h1];
                    pins.column_strobe_n <= 1'b0;
                    timer <= col_len - 24'h000001;
                    state <= ST_COL;
                end
                ST_ROW_HOLD: if (timer_done) begin
                    pins.row_strobe_n    <= 1'b1;
                    pins.column_strobe_n <= 1'b1;
                    pins.store_select_n  <= 1'b1;
                    timer <= 24'(RP_CYC - 1);
                    state <= ST_PRECHARGE;
                end
                ST_PRECHARGE: if (timer_done) state <= (init_cnt == 4'(INIT_CYCLES)) ? ST_IDLE : ST_INIT;
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign req_ready = (state == ST_IDLE) && !ref_due && req_valid;
    assign busy      = (state != ST_IDLE);
endmodule // dram_ctl
`default_nettype wire

// *** dram_ctl_monitor.sv ***
// Checker: strobe order and timing at the controller ports
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_monitor
    import dram_ctl_pkg::*;
#(parameter int REFRESH_CYCLES = REFRESH_CYC) (
    input wire logic       mclk,      // Clock
    input wire logic       rst,       // Reset
    input wire logic       req_valid, // Request
    input wire logic       req_ready, // Taken
    input wire logic       busy,      // Not idle
    input wire dram_pins_t pins       // DRAM pins
);
    logic ras, cas;
    int   gap;
    assign ras = pins.row_strobe_n;
    assign cas = pins.column_strobe_n;
    // Row-high stretch; every row activation refreshes a row
    always_ff @(posedge mclk) gap <= (rst || !ras) ? 0 : gap + 1;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    quiet_reset_a: assert property (disable iff (1'b0) rst |=> ras && cas) else $error("strobe active after reset");
    init_busy_a: assert property ($fell(rst) |-> busy[*8]) else $error("busy dropped in init");
    lead_cbr_a: assert property ($fell(ras) && !cas |-> !$past(cas)) else $error("column did not lead");
    hold_cbr_a: assert property ($fell(ras) && !cas |=> !cas) else $error("column released early");
    row_col_gap_a: assert property ($fell(cas) && !ras |-> !$past(ras)) else $error("column fell with row");
    row_width_a: assert property ($rose(ras) |-> !$past(ras, 2)) else $error("row low too short");
    refresh_gap_a: assert property (gap < REFRESH_CYCLES + 16) else $error("refresh overdue");
    taken_idle_a: assert property (req_ready |-> req_valid && !busy) else $error("request taken while busy");
    select_hold_a: assert property (!cas && !ras && !$past(cas) |-> $stable(pins.store_select_n))
        else $error("select moved");
    cbr_c: cover property ($fell(ras) && !cas);
    access_c: cover property ($fell(cas) && !ras);
    taken_c: cover property (req_ready);
endmodule // dram_ctl_monitor
bind dram_ctl dram_ctl_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES)) mon (.mclk(mclk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .busy(busy), .pins(pins));
`default_nettype wire

// *** dram_model.sv ***
// Partner model: behavioural 4M x 1 strobe DRAM
`timescale 1ns/1ps
`default_nettype none
module dram_model
    import dram_ctl_pkg::*;
(
    input wire dram_pins_t pins, // Strobes, address, data in
    output logic           q     // Data out, not latched
);
    logic                      cells [int];
    logic [ADDR_BITS-1:0]      row;
    logic [WORD_ADDR_BITS-1:0] loc;
    logic                      open_col;
    int                        refresh_row;
    initial begin
        q = 1'b0;
        open_col = 1'b0;
        refresh_row = 0;
    end
    always @(negedge pins.row_strobe_n) begin
        open_col = 1'b0;
        if (!pins.column_strobe_n) refresh_row = (refresh_row + 1) % REFRESH_ROWS;
        else row = pins.multiplexed_address;
    end
    always @(negedge pins.column_strobe_n) if (!pins.row_strobe_n) begin
        // Later falls in one row step round the 4-bit nibble
        if (open_col) {loc[10], loc[21]} = {loc[10], loc[21]} + 2'b01;
        else loc = {row, pins.multiplexed_address};
        open_col = 1'b1;
        if (!pins.store_select_n) cells[loc] = pins.input_bit;
        else begin
            q = ~(cells.exists(loc) ? cells[loc] : 1'b0);
            #25 q = cells.exists(loc) ? cells[loc] : 1'b0;
        end
    end
    // Released output flips so a stale level is never mistaken for data
    always @(posedge pins.column_strobe_n) q = ~q;
endmodule // dram_model
`default_nettype wire

// *** test_dram_ctl.sv ***
// Testbench: controller against the DRAM model
`timescale 1ns/1ps
`default_nettype none
module test_dram_ctl import dram_ctl_pkg::*; ;
    localparam int PWR = 20;
    localparam int REF = 64;
    logic        mclk, rst, req_valid, req_ready, rsp_valid, busy, output_bit;
    logic [3:0]  rsp_data, d;
    logic [21:0] a;
    logic [7:0]  exp_q [$];
    logic [3:0]  mem [int];
    dram_req_t   req;
    dram_pins_t  pins;
    int          miscompares, num_checks, rows, r0;
    dram_ctl #(.POWERUP_CYCLES(PWR), .REFRESH_CYCLES(REF)) uut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
        .pins(pins), .output_bit(output_bit));
    dram_model model (.pins(pins), .q(output_bit));
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;
    always @(negedge pins.row_strobe_n) rows++;
    task automatic check_data(input string what, input logic [7:0] e, input logic [3:0] got);
        num_checks++;
        if ((got & e[7:4]) !== e[3:0]) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e[3:0], got);
        end
    endtask
    task automatic check_flag(input string what, input logic e, input logic got);
        check_data(what, {4'h1, 3'h0, e}, {3'h0, got});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy !== 1'b0 || exp_q.size() != 0) && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 3000) begin miscompares++; stop_test(); end
    endtask
    // Held request is refused while busy and taken once idle
    task automatic access(input logic wr, input logic nib, input logic [21:0] ad, input logic [3:0] wd);
        int n;
        n = 0;
        // Let an edge pass so back-to-back calls never lower and raise valid in one step
        @(negedge mclk);
        req = '{write: wr, nibble: nib, addr: ad, wdata: wd};
        req_valid = 1'b1;
        #1;
        while (req_ready !== 1'b1 && n < 3000) begin @(negedge mclk); #1; n++; end
        @(negedge mclk);
        req_valid = 1'b0;
        if (n >= 3000) begin miscompares++; stop_test(); end
        if (!wr) exp_q.push_back({nib ? 4'hF : 4'h1, mem[ad]});
        else mem[ad] = nib ? wd : {3'h0, wd[0]};
    endtask
    always @(negedge mclk) if (rsp_valid === 1'b1) begin
        if (exp_q.size() == 0) check_flag("rsp_valid", 1'b0, 1'b1);
        else check_data("rsp_data", exp_q.pop_front(), rsp_data);
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst = 1'b1; req_valid = 1'b0; req = '0;
        void'($urandom(32'h42E8));
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        rows = 0;
        wait_idle();
        check_flag("init_rows", 1'b1, rows >= 8);
        for (int i = 0; i < 10; i++) begin
            a = $urandom; d = $urandom;
            access(1'b1, i[0], a, d);
            access(1'b0, i[0], a, 4'h0);
            wait_idle();
        end
        r0 = rows;
        repeat (3 * REF) @(negedge mclk);
        check_flag("refresh", 1'b1, rows - r0 >= 2);
        access(1'b0, 1'b1, a, 4'h0);
        wait_idle();
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        check_flag("reset_strobes", 1'b1, pins.row_strobe_n & pins.column_strobe_n);
        rst = 1'b0;
        wait_idle();
        access(1'b0, 1'b1, a, 4'h0);
        wait_idle();
        stop_test();
    end
endmodule // test_dram_ctl
`default_nettype wire
